// File: rtl/timer16_output_compare.sv
// 16-bit timer with one output compare unit behind an APB slave.
// Assumes timer_tick marks each timer clock cycle, synchronous to clk.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module timer16_output_compare (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_tick,
  input  wire logic        compare_irq_ack,
  input  wire logic        overflow_irq_ack,
  output logic             compare_irq,
  output logic             overflow_irq,
  output logic             compare_output_bit,
  output logic             pin_out,
  output logic             pin_oe
);

  typedef struct packed {
    logic [3:0]                  mode;
    logic [1:0]                  com;
    logic                        irq_en;
    logic                        port_val;
    logic                        pin_dir;
    logic [15:0]                 count;
    logic [15:0]                 cmp_active;
    logic [15:0]                 cmp_buf;
    logic [7:0]                  temp;
    timer16_oc_pkg::count_dir_t  dir;
    logic                        block;
    logic                        cmp_flag;
    logic                        ovf_flag;
    logic                        oc;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
    logic                        pin_out;
    logic                        pin_oe;
    logic                        cmp_irq;
    logic                        ovf_irq;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // PWM modes: everything except normal, clear-on-match and reserved
  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == timer16_oc_pkg::MODE_NORMAL ||
               m == timer16_oc_pkg::MODE_CTC_CMP ||
               m == timer16_oc_pkg::MODE_CTC_CAP ||
               m == timer16_oc_pkg::MODE_RSVD);
  endfunction

  // Dual-slope modes count up then down
  function automatic logic is_dual(input logic [3:0] m);
    is_dual = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hB);
  endfunction

  // Buffer reload at floor instead of top
  function automatic logic load_at_floor(input logic [3:0] m);
    load_at_floor = (m == 4'h8) || (m == 4'h9);
  endfunction

  // Counter top; compare A serves as top in 4, 9, 11, 15
  function automatic logic [15:0] top_of(input logic [3:0]  m,
                                         input logic [15:0] cmp);
    case (m)
      4'h1, 4'h5: top_of = timer16_oc_pkg::TOP_8BIT;
      4'h2, 4'h6: top_of = timer16_oc_pkg::TOP_9BIT;
      4'h3, 4'h7: top_of = timer16_oc_pkg::TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = cmp; // RL17
      default: top_of = timer16_oc_pkg::COUNT_MAX;
    endcase
  endfunction

  // Non-PWM match action on the output bit
  function automatic logic plain_action(input logic [1:0] com,
                                        input logic       oc);
    case (com)
      timer16_oc_pkg::COM_TOGGLE: plain_action = ~oc; // RL20
      timer16_oc_pkg::COM_CLEAR:  plain_action = 1'b0; // RL22
      timer16_oc_pkg::COM_SET:    plain_action = 1'b1; // RL22
      default:                    plain_action = oc; // RL15
    endcase
  endfunction

  // Bus phase decode
  logic        acc;
  logic        done;
  logic        wr;
  logic [7:0]  wdat;
  logic        cnt_wr;
  logic        force_wr;
  logic        match;
  logic        hit;
  logic [15:0] top;
  logic        at_top;
  logic        at_floor;

  assign acc      = psel & penable & ~s_r.pready;
  assign done     = psel & penable & s_r.pready;
  assign wr       = done & pwrite & pstrb[0] & ~s_r.pslverr;
  assign wdat     = pwdata[7:0];
  assign cnt_wr   = wr & (paddr == timer16_oc_pkg::OFF_CNT_LO);
  assign force_wr = wr & (paddr == timer16_oc_pkg::OFF_FORCE) &
                    wdat[timer16_oc_pkg::FORCE_BIT] & ~is_pwm(s_r.mode);
  assign match    = (s_r.count == s_r.cmp_active); // RL1
  assign hit      = timer_tick & match & ~s_r.block; // RL9
  assign top      = top_of(s_r.mode, s_r.cmp_active);
  assign at_top   = (s_r.count == top);
  assign at_floor = (s_r.count == timer16_oc_pkg::COUNT_FLOOR);

  // Next state of the whole block
  always_comb begin
    logic        mapped;
    logic [31:0] rd;
    logic        cmp_set;
    logic        ovf_set;
    logic        reload;
    mapped  = 1'b1;
    rd      = 32'h0000_0000;
    cmp_set = 1'b0;
    ovf_set = 1'b0;
    reload  = 1'b0;
    s_nxt   = s_r;

    // Read path, sampled in the first access cycle
    if (paddr == timer16_oc_pkg::OFF_CTRL) begin
      rd[7:0] = {1'b0, s_r.irq_en, s_r.com, s_r.mode};
    end else if (paddr == timer16_oc_pkg::OFF_FORCE) begin
      rd[7:0] = 8'h00;
    end else if (paddr == timer16_oc_pkg::OFF_FLAGS) begin
      rd[7:0] = {6'h00, s_r.ovf_flag, s_r.cmp_flag};
    end else if (paddr == timer16_oc_pkg::OFF_CNT_LO) begin
      rd[7:0] = s_r.count[7:0];
    end else if (paddr == timer16_oc_pkg::OFF_CNT_HI) begin
      rd[7:0] = s_r.temp;
    end else if (paddr == timer16_oc_pkg::OFF_CMP_LO) begin
      rd[7:0] = is_pwm(s_r.mode) ? s_r.cmp_buf[7:0] // RL5
                                 : s_r.cmp_active[7:0];
    end else if (paddr == timer16_oc_pkg::OFF_CMP_HI) begin
      rd[7:0] = is_pwm(s_r.mode) ? s_r.cmp_buf[15:8] // RL6
                                 : s_r.cmp_active[15:8];
    end else if (paddr == timer16_oc_pkg::OFF_PORT) begin
      rd[7:0] = {6'h00, s_r.pin_dir, s_r.port_val};
    end else begin
      mapped = 1'b0;
    end

    // APB answer one cycle into the access phase
    s_nxt.pready  = acc;
    s_nxt.pslverr = acc & ~mapped;
    if (acc) begin
      s_nxt.prdata = rd;
      if (!pwrite && paddr == timer16_oc_pkg::OFF_CNT_LO) begin
        s_nxt.temp = s_r.count[15:8];
      end
    end

    // Counter sequence, driven by mode only
    if (timer_tick) begin
      s_nxt.block = 1'b0;
      if (is_dual(s_r.mode)) begin
        if (s_r.dir == timer16_oc_pkg::DIR_UP) begin
          if (at_top) begin
            s_nxt.dir   = timer16_oc_pkg::DIR_DOWN;
            s_nxt.count = s_r.count - 16'h0001;
            reload      = ~load_at_floor(s_r.mode);
          end else begin
            s_nxt.count = s_r.count + 16'h0001;
          end
        end else if (at_floor) begin
          s_nxt.dir   = timer16_oc_pkg::DIR_UP;
          s_nxt.count = s_r.count + 16'h0001;
          ovf_set     = 1'b1;
          reload      = load_at_floor(s_r.mode);
        end else begin
          s_nxt.count = s_r.count - 16'h0001;
        end
      end else if (s_r.mode != timer16_oc_pkg::MODE_NORMAL && at_top) begin
        s_nxt.count = timer16_oc_pkg::COUNT_FLOOR; // RL16
        s_nxt.dir   = timer16_oc_pkg::DIR_UP;
        ovf_set     = is_pwm(s_r.mode) |
                      (s_r.count == timer16_oc_pkg::COUNT_MAX);
        reload      = is_pwm(s_r.mode); // RL4
      end else begin
        s_nxt.count = s_r.count + 16'h0001; // RL18
        s_nxt.dir   = timer16_oc_pkg::DIR_UP;
        ovf_set     = (s_r.count == timer16_oc_pkg::COUNT_MAX); // RL19
      end
    end
    cmp_set = hit; // RL2

    // Fast PWM: top restores the idle level
    if (timer_tick && is_pwm(s_r.mode) && !is_dual(s_r.mode) && at_top) begin
      if (s_r.com == timer16_oc_pkg::COM_CLEAR) begin
        s_nxt.oc = 1'b0; // RL21
      end else if (s_r.com == timer16_oc_pkg::COM_SET) begin
        s_nxt.oc = 1'b1; // RL21
      end
    end

    // Match action with the live action setting
    if (hit) begin
      if (!is_pwm(s_r.mode)) begin
        s_nxt.oc = plain_action(s_r.com, s_r.oc); // RL13
      end else if (is_dual(s_r.mode)) begin
        if (s_r.com == timer16_oc_pkg::COM_CLEAR) begin
          s_nxt.oc = (s_r.dir == timer16_oc_pkg::DIR_DOWN);
        end else if (s_r.com == timer16_oc_pkg::COM_SET) begin
          s_nxt.oc = (s_r.dir == timer16_oc_pkg::DIR_UP);
        end
      end else if (s_r.com == timer16_oc_pkg::COM_CLEAR) begin
        s_nxt.oc = 1'b1; // RL21
      end else if (s_r.com == timer16_oc_pkg::COM_SET) begin
        s_nxt.oc = 1'b0; // RL21
      end
    end else if (force_wr) begin
      s_nxt.oc = plain_action(s_r.com, s_r.oc); // RL8
    end

    // Compare buffer reload at top or floor
    if (reload) begin
      s_nxt.cmp_active = s_r.cmp_buf; // RL4
    end

    // Register writes, effective at the completing edge
    if (wr) begin
      if (paddr == timer16_oc_pkg::OFF_CTRL) begin
        s_nxt.mode   = wdat[timer16_oc_pkg::CTRL_MODE_LSB +: 4]; // RL11
        s_nxt.com    = wdat[timer16_oc_pkg::CTRL_COM_LSB +: 2]; // RL13
        s_nxt.irq_en = wdat[timer16_oc_pkg::CTRL_IRQ_BIT];
      end else if (paddr == timer16_oc_pkg::OFF_PORT) begin
        s_nxt.port_val = wdat[timer16_oc_pkg::PORT_VAL_BIT];
        s_nxt.pin_dir  = wdat[timer16_oc_pkg::PORT_DIR_BIT];
      end else if (paddr == timer16_oc_pkg::OFF_CNT_HI ||
                   paddr == timer16_oc_pkg::OFF_CMP_HI) begin
        s_nxt.temp = wdat; // RL7
      end else if (paddr == timer16_oc_pkg::OFF_CNT_LO) begin
        s_nxt.count = {s_r.temp, wdat}; // RL9
        s_nxt.block = 1'b1; // RL9
      end else if (paddr == timer16_oc_pkg::OFF_CMP_LO) begin
        s_nxt.cmp_buf = {s_r.temp, wdat}; // RL7
        if (!is_pwm(s_r.mode)) begin
          s_nxt.cmp_active = {s_r.temp, wdat}; // RL5
        end
      end
    end

    // Sticky flags: setting beats clearing
    s_nxt.cmp_flag = (s_r.cmp_flag & ~compare_irq_ack &
                      ~(wr && paddr == timer16_oc_pkg::OFF_FLAGS &&
                        wdat[timer16_oc_pkg::FLAG_CMP_BIT])) | cmp_set; // RL3
    s_nxt.ovf_flag = (s_r.ovf_flag & ~overflow_irq_ack &
                      ~(wr && paddr == timer16_oc_pkg::OFF_FLAGS &&
                        wdat[timer16_oc_pkg::FLAG_OVF_BIT])) | ovf_set; // RL19

    // Registered outputs
    s_nxt.cmp_irq = s_nxt.cmp_flag & s_nxt.irq_en; // RL3
    s_nxt.ovf_irq = s_nxt.ovf_flag;
    s_nxt.pin_out = (s_nxt.com != timer16_oc_pkg::COM_NONE) ? s_nxt.oc
                                                            : s_nxt.port_val; // RL14
    s_nxt.pin_oe  = s_nxt.pin_dir; // RL14
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r            <= '0;
      s_r.mode       <= timer16_oc_pkg::MODE_RST;
      s_r.com        <= timer16_oc_pkg::COM_RST;
      s_r.count      <= timer16_oc_pkg::COUNT_RST;
      s_r.cmp_active <= timer16_oc_pkg::CMP_RST;
      s_r.cmp_buf    <= timer16_oc_pkg::CMP_RST;
      s_r.temp       <= timer16_oc_pkg::TEMP_RST;
      s_r.dir        <= timer16_oc_pkg::DIR_UP;
      s_r.oc         <= 1'b0; // RL12
    end else begin
      s_r <= s_nxt;
    end
  end

  // Ports straight from the state register
  assign prdata             = s_r.prdata;
  assign pready             = s_r.pready;
  assign pslverr            = s_r.pslverr;
  assign compare_irq        = s_r.cmp_irq;
  assign overflow_irq       = s_r.ovf_irq;
  assign compare_output_bit = s_r.oc;
  assign pin_out            = s_r.pin_out;
  assign pin_oe             = s_r.pin_oe;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence live_match;
    timer_tick && match && !s_r.block;
  endsequence

  sequence blocked_tick;
    timer_tick && s_r.block;
  endsequence

  chk_flag_next_tick: assert property ( // RL2
    live_match |=> s_r.cmp_flag)
    else $error("match did not set compare flag");

  chk_flag_rise_cause: assert property ( // RL2
    $rose(s_r.cmp_flag) |-> $past(timer_tick) && $past(match))
    else $error("compare flag rose without a match");

  chk_irq_gating: assert property ( // RL3
    s_r.cmp_irq == (s_r.cmp_flag && s_r.irq_en))
    else $error("compare interrupt not gated by enable");

  chk_write_blocks: assert property ( // RL9
    cnt_wr |=> s_r.block)
    else $error("count write did not arm match blocking");

  chk_blocked_quiet: assert property ( // RL9
    (blocked_tick and !s_r.cmp_flag) |=> !s_r.cmp_flag)
    else $error("blocked match still set compare flag");

  chk_force_no_flag: assert property ( // RL8
    force_wr && !timer_tick && !s_r.cmp_flag |=> !s_r.cmp_flag && $stable(s_r.count))
    else $error("force strobe touched flag or counter");

  chk_reset_oc_low: assert property ( // RL12
    $rose(reset_n) |-> !s_r.oc)
    else $error("output bit not cleared by reset");

  chk_pin_override: assert property ( // RL14
    s_r.com != timer16_oc_pkg::COM_NONE |-> pin_out == s_r.oc)
    else $error("pin not overridden by output bit");

  chk_normal_wrap: assert property ( // RL18
    timer_tick && !cnt_wr && s_r.mode == timer16_oc_pkg::MODE_NORMAL &&
    s_r.count == timer16_oc_pkg::COUNT_MAX
    |=> s_r.count == timer16_oc_pkg::COUNT_FLOOR && s_r.ovf_flag ##1 s_r.ovf_irq)
    else $error("normal mode wrap or overflow wrong");

  chk_com_zero_hold: assert property ( // RL15
    s_r.com == timer16_oc_pkg::COM_NONE && hit |=> $stable(s_r.oc))
    else $error("action zero changed the output bit");

  chk_top_reload: assert property ( // RL4
    timer_tick && is_pwm(s_r.mode) && !is_dual(s_r.mode) && at_top
    |=> s_r.cmp_active == $past(s_r.cmp_buf))
    else $error("compare buffer not loaded at top");

  chk_high_read: assert property ( // RL6
    acc && !pwrite && paddr == timer16_oc_pkg::OFF_CMP_HI &&
    !is_pwm(s_r.mode) |=> prdata[7:0] == $past(s_r.cmp_active[15:8]))
    else $error("compare high read not taken from register");

  chk_ctc_toggle: assert property ( // RL20
    s_r.mode == timer16_oc_pkg::MODE_CTC_CMP &&
    s_r.com == timer16_oc_pkg::COM_TOGGLE && hit
    |=> s_r.oc != $past(s_r.oc))
    else $error("toggle action did not invert output bit");

endmodule

`default_nettype wire

// File: rtl/timer16_oc_pkg.sv
// Constants for the 16-bit timer output compare block.
// Assumes an APB master with 32-bit data; registers sit in bits 7:0.
//
// Operation
// RL1: Comparator checks count against compare value always
// RL2: Match flag sets one timer tick later
// RL3: Flag with enable raises interrupt; ack/W1C clears
// RL4: PWM modes double buffer; others write directly
// RL5: CPU reaches buffer or active compare register
// RL6: Only CPU changes compare; high read direct
// RL7: High byte to latch; low write loads all
// RL8: Force strobe acts on output, not flag/counter
// RL9: Count write blocks matches on next tick
// RL10: Software avoids writing count equal to top
// RL11: Output bit survives waveform mode changes
// RL12: Reset clears the output bit to zero
// RL13: Output action unbuffered, used at next match
// RL14: Nonzero action overrides port; direction bit stays
// RL15: Action zero leaves output bit unchanged
// RL16: Action setting never alters counting sequence
// RL17: Compare A can define counter top
// RL18: Normal mode increments and wraps at max
// RL19: Normal overflow flag sets when count wraps
// RL20: Clear-on-match action one toggles output
// RL21: Fast PWM action two non-inverted, three inverted; code: two sets at match and clears at top, three the reverse
// RL22: Non-PWM action two clears, three sets
package timer16_oc_pkg;

  // Register byte addresses
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_FORCE  = 8'h04;
  localparam logic [7:0] OFF_FLAGS  = 8'h08;
  localparam logic [7:0] OFF_CNT_LO = 8'h0C;
  localparam logic [7:0] OFF_CNT_HI = 8'h10;
  localparam logic [7:0] OFF_CMP_LO = 8'h14;
  localparam logic [7:0] OFF_CMP_HI = 8'h18;
  localparam logic [7:0] OFF_PORT   = 8'h1C;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_COM_LSB  = 4;
  localparam int CTRL_IRQ_BIT  = 6;
  localparam int FORCE_BIT     = 0;
  localparam int FLAG_CMP_BIT  = 0;
  localparam int FLAG_OVF_BIT  = 1;
  localparam int PORT_VAL_BIT  = 0;
  localparam int PORT_DIR_BIT  = 1;

  // Reset values
  localparam logic [3:0]  MODE_RST  = 4'h0;
  localparam logic [1:0]  COM_RST   = 2'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST   = 16'h0000;
  localparam logic [7:0]  TEMP_RST  = 8'h00;

  // Count limits
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  localparam logic [15:0] TOP_8BIT    = 16'h00FF;
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;

  // Waveform modes named by the block
  localparam logic [3:0] MODE_NORMAL   = 4'h0;
  localparam logic [3:0] MODE_CTC_CMP  = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP  = 4'hC;
  localparam logic [3:0] MODE_RSVD     = 4'hD;

  // Output action codes
  localparam logic [1:0] COM_NONE   = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  typedef enum logic [0:0] {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_t;

endpackage

// File: dv/irq_service_model.sv
// CPU side model that services the timer interrupt requests.
// Assumes a level request and a one-cycle acknowledge pulse back.
`timescale 1ns/1ps
`default_nettype none

module irq_service_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       service_on,
  input  wire logic [3:0] wait_cycles,
  input  wire logic       irq,
  output logic            ack
);
  logic [3:0] wait_r;

  // Answers a pending request after wait_cycles clocks, promptly or slowly
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 4'h0;
      ack    <= 1'b0;
    end else if (!service_on || !irq || ack) begin
      wait_r <= 4'h0;
      ack    <= 1'b0;
    end else if (wait_r == wait_cycles) begin
      ack    <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

`default_nettype wire

// File: dv/timer16_output_compare_tb.sv
// Self-checking bench for the 16-bit timer output compare block.
// Assumes the APB slave answers with one wait state, ticks from the bench.
`timescale 1ns/1ps
`default_nettype none

module timer16_output_compare_tb;
  localparam int LIMIT = 5000;
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer_tick;
  logic        cmp_ack;
  logic        ovf_ack;
  logic        compare_irq;
  logic        overflow_irq;
  logic        out_bit;
  logic        pin_out;
  logic        pin_oe;
  logic        pin_level;
  logic        svc_on;
  logic [3:0]  svc_wait;
  logic        last_err;
  logic [7:0]  rd;
  logic [15:0] v16;
  logic [15:0] keep;
  int          err_count;
  int          checks_done;
  int          cycles;
  int          n;
  logic [1:0]  acts [6];
  logic        bits [6];

  timer16_output_compare timer16_output_compare_inst (
    .clk                (clk),
    .reset_n            (reset_n),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .timer_tick         (timer_tick),
    .compare_irq_ack    (cmp_ack),
    .overflow_irq_ack   (ovf_ack),
    .compare_irq        (compare_irq),
    .overflow_irq       (overflow_irq),
    .compare_output_bit (out_bit),
    .pin_out            (pin_out),
    .pin_oe             (pin_oe)
  );

  irq_service_model cmp_svc (.clk(clk), .reset_n(reset_n),
    .service_on(svc_on), .wait_cycles(svc_wait), .irq(compare_irq),
    .ack(cmp_ack));
  irq_service_model ovf_svc (.clk(clk), .reset_n(reset_n),
    .service_on(svc_on), .wait_cycles(svc_wait), .irq(overflow_irq),
    .ack(ovf_ack));

  // Pad with a pull-down while nobody drives it
  assign pin_level = pin_oe ? pin_out : 1'b0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out;
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer: setup, access, hold until pready
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd       = prdata[7:0];
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) chk("pready", 16'h0001, 16'h0000);
  endtask

  task automatic set16(input logic [7:0] hi, input logic [15:0] v);
    xfer(hi, 1'b1, v[15:8]);
    xfer(hi - 8'h04, 1'b1, v[7:0]);
  endtask

  task automatic get16(input logic [7:0] lo);
    xfer(lo, 1'b0, 8'h00);
    v16[7:0] = rd;
    xfer(lo + 8'h04, 1'b0, 8'h00);
    v16[15:8] = rd;
  endtask

  task automatic ctrl(input logic [7:0] d);
    xfer(timer16_oc_pkg::OFF_CTRL, 1'b1, d);
  endtask

  task automatic flags(input logic [7:0] e);
    xfer(timer16_oc_pkg::OFF_FLAGS, 1'b0, 8'h00);
    chk("flags", 16'(e), 16'(rd));
  endtask

  task automatic force_out;
    xfer(timer16_oc_pkg::OFF_FORCE, 1'b1, 8'h01);
    @(negedge clk);
  endtask

  // Holds timer_tick high for k timer clock cycles
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      timer_tick <= 1'b1;
    end
    @(posedge clk);
    timer_tick <= 1'b0;
    @(negedge clk);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      chk("run length", 16'h0000, 16'h0001);
      close_out();
    end
  end

  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h00000000; pstrb = 4'hF;
    timer_tick = 1'b0; svc_on = 1'b0; svc_wait = 4'h2;
    err_count = 0; checks_done = 0; cycles = 0;
    acts = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h2, 2'h3};
    bits = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("output bit", 16'h0000, 16'(out_bit));
    chk("pin enable", 16'h0000, 16'(pin_oe));
    // Masked byte ignored, unmapped address refused
    @(posedge clk);
    pstrb <= 4'h0;
    ctrl(8'h44);
    pstrb <= 4'hF;
    xfer(timer16_oc_pkg::OFF_CTRL, 1'b0, 8'h00);
    chk("ctrl", 16'h0000, 16'(rd));
    xfer(8'h20, 1'b1, 8'h01);
    chk("slave error", 16'h0001, 16'(last_err));
    // Compare access and match timing
    ctrl(8'h40);
    set16(timer16_oc_pkg::OFF_CMP_HI, 16'h0105);
    get16(timer16_oc_pkg::OFF_CNT_LO);
    xfer(timer16_oc_pkg::OFF_CMP_HI, 1'b0, 8'h00);
    chk("cmp high", 16'h0001, 16'(rd));
    xfer(timer16_oc_pkg::OFF_CMP_LO, 1'b0, 8'h00);
    chk("cmp low", 16'h0005, 16'(rd));
    set16(timer16_oc_pkg::OFF_CNT_HI, 16'h0105);
    tick(1);
    get16(timer16_oc_pkg::OFF_CNT_LO);
    chk("count", 16'h0106, v16);
    flags(8'h00);
    set16(timer16_oc_pkg::OFF_CNT_HI, 16'h0103);
    tick(2);
    flags(8'h00);
    tick(1);
    chk("cmp irq", 16'h0001, 16'(compare_irq));
    flags(8'h01);
    xfer(timer16_oc_pkg::OFF_FLAGS, 1'b1, 8'h01);
    flags(8'h00);
    chk("cmp irq", 16'h0000, 16'(compare_irq));
    // Serviced interrupt clears the flag
    svc_on <= 1'b1;
    set16(timer16_oc_pkg::OFF_CNT_HI, 16'h0104);
    tick(2);
    chk("cmp irq", 16'h0001, 16'(compare_irq));
    for (n = 0; n < 30 && compare_irq !== 1'b0; n++) @(negedge clk);
    flags(8'h00);
    // Overflow in normal mode, slow service
    svc_wait <= 4'h9;
    set16(timer16_oc_pkg::OFF_CNT_HI, 16'hFFFE);
    tick(2);
    chk("ovf irq", 16'h0001, 16'(overflow_irq));
    tick(1);
    chk("ovf irq", 16'h0001, 16'(overflow_irq));
    for (n = 0; n < 30 && overflow_irq !== 1'b0; n++) @(negedge clk);
    flags(8'h00);
    get16(timer16_oc_pkg::OFF_CNT_LO);
    chk("count", 16'h0001, v16);
    // Force strobe through every action code
    svc_on <= 1'b0;
    ctrl(8'h00);
    get16(timer16_oc_pkg::OFF_CNT_LO);
    keep = v16;
    for (int i = 0; i < 6; i++) begin
      ctrl({2'b00, acts[i], 4'h0});
      force_out();
      chk("forced bit", 16'(bits[i]), 16'(out_bit));
    end
    get16(timer16_oc_pkg::OFF_CNT_LO);
    chk("count", keep, v16);
    flags(8'h00);
    // Port override and direction
    xfer(timer16_oc_pkg::OFF_PORT, 1'b1, 8'h02);
    @(negedge clk);
    chk("pin", 16'h0001, 16'(pin_level));
    ctrl(8'h00);
    @(negedge clk);
    chk("pin", 16'h0000, 16'(pin_level));
    chk("pin enable", 16'h0001, 16'(pin_oe));
    ctrl(8'h25);
    force_out();
    chk("bit kept", 16'h0001, 16'(out_bit));
    // Clear on match with toggle
    ctrl(8'h14);
    set16(timer16_oc_pkg::OFF_CMP_HI, 16'h0002);
    set16(timer16_oc_pkg::OFF_CNT_HI, 16'h0000);
    tick(2);
    chk("toggle", 16'h0001, 16'(out_bit));
    tick(1);
    chk("toggle", 16'h0000, 16'(out_bit));
    get16(timer16_oc_pkg::OFF_CNT_LO);
    chk("count", 16'h0000, v16);
    tick(3);
    chk("toggle", 16'h0001, 16'(out_bit));
    // Fast PWM with buffered compare, fixed top
    ctrl(8'h20);
    force_out();
    set16(timer16_oc_pkg::OFF_CMP_HI, 16'h0010);
    ctrl(8'h25);
    set16(timer16_oc_pkg::OFF_CMP_HI, 16'h0020);
    get16(timer16_oc_pkg::OFF_CMP_LO);
    chk("cmp buffer", 16'h0020, v16);
    xfer(timer16_oc_pkg::OFF_FLAGS, 1'b1, 8'h03);
    set16(timer16_oc_pkg::OFF_CNT_HI, 16'h000F);
    tick(2);
    chk("pwm set", 16'h0001, 16'(out_bit));
    flags(8'h01);
    set16(timer16_oc_pkg::OFF_CNT_HI, 16'h00FE);
    tick(2);
    chk("pwm top", 16'h0000, 16'(out_bit));
    ctrl(8'h35);
    set16(timer16_oc_pkg::OFF_CNT_HI, 16'h00FE);
    tick(2);
    chk("inv top", 16'h0001, 16'(out_bit));
    set16(timer16_oc_pkg::OFF_CNT_HI, 16'h001F);
    tick(2);
    chk("inv match", 16'h0000, 16'(out_bit));
    close_out();
  end
endmodule

`default_nettype wire
